// file: design/mclh_pkg.sv
// Package with constants, register map and variant, lead and configuration types of the control-lead block.
package mclh_pkg;

  localparam int          MCLH_CLK_HZ        = 20000000;
  localparam int          MCLH_CTS_DELAY_US  = 100;
  localparam int          MCLH_CTS_DELAY_CYC = (MCLH_CTS_DELAY_US * (MCLH_CLK_HZ / 1000000) > 0) ?
                                               MCLH_CTS_DELAY_US * (MCLH_CLK_HZ / 1000000) : 1;

  localparam logic [7:0]  MCLH_ADR_CTRL  = 8'h00;
  localparam logic [7:0]  MCLH_ADR_STAT  = 8'h04;
  localparam logic [7:0]  MCLH_ADR_IRQ   = 8'h08;
  localparam logic [7:0]  MCLH_ADR_MASK  = 8'h0C;
  localparam logic [7:0]  MCLH_ADR_ID    = 8'h10;

  localparam int          MCLH_CTRL_VARIANT_LO = 0;
  localparam int          MCLH_CTRL_FLOW       = 2;
  localparam int          MCLH_CTRL_GATE       = 3;
  localparam int          MCLH_CTRL_POL        = 4;
  localparam int          MCLH_CTRL_DSR_EIA    = 5;
  localparam logic [5:0]  MCLH_CTRL_RESET      = 6'h00;

  localparam int          MCLH_EV_CTS_ON  = 0;
  localparam int          MCLH_EV_CTS_OFF = 1;
  localparam int          MCLH_EV_CD_LOST = 2;
  localparam int          MCLH_EV_CD_UP   = 3;
  localparam int          MCLH_EV_LLB     = 4;
  localparam int          MCLH_EV_RLB     = 5;
  localparam int          MCLH_EV_W       = 6;

  localparam logic [31:0] MCLH_ID_VALUE = 32'h00C0FFEE;

  typedef enum logic [1:0] {
    MCLH_VAR_LOW_BIAS,
    MCLH_VAR_HIGH_BIAS,
    MCLH_VAR_BALANCED,
    MCLH_VAR_RSVD
  } mclh_variant_t;

  typedef struct packed {
    logic rts;
    logic loop_local;
    logic loop_remote;
  } mclh_lead_in_t;

  typedef struct packed {
    mclh_variant_t variant;
    logic          flow_ctrl;
    logic          cts_gate_cd;
    logic          alarm_polarity_select;
    logic          dsr_eia;
  } mclh_cfg_t;

endpackage

// file: design/mclh_sync.sv
// Two-stage synchroniser for a group of asynchronous input leads.
module mclh_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("mclh_sync: WIDTH must be at least one");
    end
  end

  // The first stage feeds only the second stage, so metastability never reaches logic.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: design/mclh_top.sv
// Control-lead logic of the fiber modem user interface with a Wishbone register file.
module mclh_top
  import mclh_pkg::*;
#(
  parameter int CTS_DELAY_CYC = MCLH_CTS_DELAY_CYC
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        RTS_IN,
  input  wire logic        RTS_CONNECTED,
  input  wire logic        LOOP_LOCAL_IN,
  input  wire logic        LOOP_REMOTE_IN,
  input  wire logic        OPTICAL_CARRIER_VALID,
  input  wire logic        IFACE_TEST_ACTIVE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             CTS_OUT,
  output logic             DSR_OUT,
  output logic             TEST_MODE_OUT,
  output logic             LOCAL_LOOP_START,
  output logic             REMOTE_LOOP_START,
  output logic             FAR_DCD_CTRL,
  output logic             ALARM_CONTACT_CLOSED,
  output logic             IRQ
);

  import mclh_pkg::*;

  initial begin
    if (CTS_DELAY_CYC < 1 || CTS_DELAY_CYC > 65535) begin
      $error("mclh_top: CTS_DELAY_CYC out of range");
    end
  end

  function automatic logic rts_effective(input mclh_variant_t v, input logic conn, input logic lvl);
    logic r;
    r = lvl;
    if (!conn) begin
      r = (v == MCLH_VAR_HIGH_BIAS);
    end
    return r;
  endfunction

  logic [5:0]          ctrl_q;
  logic [MCLH_EV_W-1:0] irq_stat_q;
  logic [MCLH_EV_W-1:0] irq_mask_q;
  logic [15:0]         delay_cnt_q;
  logic                cts_q;
  logic                cd_seen_q;
  logic                cd_prev_q;
  logic                llb_q;
  logic                rlb_q;
  logic                llb_prev_q;
  logic                rlb_prev_q;
  logic [2:0]          leads_sync;
  mclh_lead_in_t       lead_sync;
  mclh_cfg_t           cfg;

  // Raw RTS and loopback leads are asynchronous to the modem clock; they are only used after this.
  mclh_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk      (SYS_CLK),
    .rst      (RST),
    .async_in ({rts_effective(cfg.variant, RTS_CONNECTED, RTS_IN), LOOP_LOCAL_IN, LOOP_REMOTE_IN}),
    .sync_out (leads_sync)
  );

  assign lead_sync = mclh_lead_in_t'(leads_sync);

  wire logic [1:0] var_bits = ctrl_q[MCLH_CTRL_VARIANT_LO +: 2];
  // The reserved variant code behaves like the low-bias part, the safe choice.
  assign cfg.variant               = (var_bits == 2'h3) ? MCLH_VAR_LOW_BIAS : mclh_variant_t'(var_bits);
  assign cfg.flow_ctrl             = ctrl_q[MCLH_CTRL_FLOW];
  assign cfg.cts_gate_cd           = ctrl_q[MCLH_CTRL_GATE];
  assign cfg.alarm_polarity_select = ctrl_q[MCLH_CTRL_POL];
  assign cfg.dsr_eia               = ctrl_q[MCLH_CTRL_DSR_EIA];

  wire logic rts_s      = lead_sync.rts;
  wire logic testing    = llb_q | rlb_q;
  // The grant condition uses only local leads and local carrier state.
  wire logic cts_want   = rts_s & (!cfg.cts_gate_cd | OPTICAL_CARRIER_VALID);
  wire logic delay_done = (delay_cnt_q == 16'(CTS_DELAY_CYC));
  wire logic cts_d      = cts_want & delay_done;
  wire logic alarm      = !(OPTICAL_CARRIER_VALID & cd_seen_q);
  // Polarity clear means the contact closes on alarm; set means it opens.
  wire logic contact_d  = cfg.alarm_polarity_select ? !alarm : alarm;
  // Default DSR drops during any test; EIA mode keeps it on only while the test runs through the interface.
  wire logic dsr_d      = cfg.dsr_eia ? (!testing | IFACE_TEST_ACTIVE) : !testing;

  wire logic [MCLH_EV_W-1:0] events = {
    rlb_q & !rlb_prev_q,
    llb_q & !llb_prev_q,
    OPTICAL_CARRIER_VALID & !cd_prev_q,
    !OPTICAL_CARRIER_VALID & cd_prev_q,
    cts_q & !cts_d,
    !cts_q & cts_d
  };

  wire logic        wb_req   = WB_CYC_I & WB_STB_I & !WB_ACK_O;
  wire logic        wb_wr    = wb_req & WB_WE_I & WB_SEL_I[0];
  wire logic        wr_ctrl  = wb_wr & (WB_ADR_I == MCLH_ADR_CTRL);
  wire logic        wr_irq   = wb_wr & (WB_ADR_I == MCLH_ADR_IRQ);
  wire logic        wr_mask  = wb_wr & (WB_ADR_I == MCLH_ADR_MASK);
  wire logic [31:0] stat_word = {24'h000000, alarm, cd_seen_q, rlb_q, llb_q, DSR_OUT, CTS_OUT, rts_s,
                                 OPTICAL_CARRIER_VALID};
  wire logic [31:0] rd_data  =
    (WB_ADR_I == MCLH_ADR_CTRL) ? {26'h0000000, ctrl_q} :
    (WB_ADR_I == MCLH_ADR_STAT) ? stat_word :
    (WB_ADR_I == MCLH_ADR_IRQ)  ? {26'h0000000, irq_stat_q} :
    (WB_ADR_I == MCLH_ADR_MASK) ? {26'h0000000, irq_mask_q} :
    (WB_ADR_I == MCLH_ADR_ID)   ? MCLH_ID_VALUE : 32'h00000000;

  // Set beats clear so an event landing on the clearing write is kept.
  wire logic [MCLH_EV_W-1:0] irq_stat_d =
    events | (irq_stat_q & ~(wr_irq ? WB_DAT_I[MCLH_EV_W-1:0] : '0));

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_q     <= MCLH_CTRL_RESET;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      IRQ        <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= WB_DAT_I[5:0];
      end
      if (wr_mask) begin
        irq_mask_q <= WB_DAT_I[MCLH_EV_W-1:0];
      end
      irq_stat_q <= irq_stat_d;
      IRQ        <= |(irq_stat_d & irq_mask_q);
    end
  end

  // The delay restarts whenever the grant condition drops, so brief RTS glitches never grant.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      delay_cnt_q <= 16'h0000;
    end else if (!cts_want) begin
      delay_cnt_q <= 16'h0000;
    end else if (!delay_done) begin
      delay_cnt_q <= delay_cnt_q + 16'h0001;
    end
  end

  // Reset values hold CTS off, tests idle and the alarm active.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cts_q                <= 1'b0;
      CTS_OUT              <= 1'b0;
      cd_seen_q            <= 1'b0;
      cd_prev_q            <= 1'b0;
      llb_q                <= 1'b0;
      rlb_q                <= 1'b0;
      llb_prev_q           <= 1'b0;
      rlb_prev_q           <= 1'b0;
      DSR_OUT              <= 1'b0;
      TEST_MODE_OUT        <= 1'b0;
      LOCAL_LOOP_START     <= 1'b0;
      REMOTE_LOOP_START    <= 1'b0;
      FAR_DCD_CTRL         <= 1'b0;
      ALARM_CONTACT_CLOSED <= 1'b1;
    end else begin
      cts_q                <= cts_d;
      CTS_OUT              <= cts_d;
      cd_seen_q            <= cd_seen_q | OPTICAL_CARRIER_VALID;
      cd_prev_q            <= OPTICAL_CARRIER_VALID;
      llb_q                <= lead_sync.loop_local;
      rlb_q                <= lead_sync.loop_remote;
      llb_prev_q           <= llb_q;
      rlb_prev_q           <= rlb_q;
      DSR_OUT              <= dsr_d;
      TEST_MODE_OUT        <= testing;
      LOCAL_LOOP_START     <= llb_q;
      REMOTE_LOOP_START    <= rlb_q;
      // Only RTS is ever sent to the far end, and only under flow control; DTR has no path.
      FAR_DCD_CTRL         <= cfg.flow_ctrl & rts_s;
      ALARM_CONTACT_CLOSED <= contact_d;
    end
  end

  a_cts_needs_rts: assert property (@(posedge SYS_CLK) disable iff (RST)
    CTS_OUT |-> $past(rts_s)) else $error("CTS asserted without RTS");

  a_cts_gate_cd: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CTS_OUT && $past(cfg.cts_gate_cd)) |-> $past(OPTICAL_CARRIER_VALID))
    else $error("CTS without carrier when gated");

  a_cts_delay_min: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(CTS_OUT) |-> $past(delay_cnt_q) == 16'(CTS_DELAY_CYC)) else $error("CTS rose before delay");

  a_far_dcd_local: assert property (@(posedge SYS_CLK) disable iff (RST)
    FAR_DCD_CTRL |-> $past(cfg.flow_ctrl)) else $error("Far DCD driven without flow control");

  a_alarm_contact: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 ALARM_CONTACT_CLOSED == ($past(cfg.alarm_polarity_select) ^ $past(alarm)))
    else $error("Alarm contact wrong");

  a_alarm_no_carrier: assert property (@(posedge SYS_CLK) disable iff (RST)
    !OPTICAL_CARRIER_VALID |=> (ALARM_CONTACT_CLOSED != $past(cfg.alarm_polarity_select)))
    else $error("Alarm not raised without carrier");

  a_dsr_default: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!cfg.dsr_eia && testing) |=> !DSR_OUT) else $error("DSR on during test");

  a_dsr_eia: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cfg.dsr_eia && testing) |=> (DSR_OUT == $past(IFACE_TEST_ACTIVE))) else $error("DSR wrong in EIA mode");

  a_test_mode: assert property (@(posedge SYS_CLK) disable iff (RST)
    testing |=> TEST_MODE_OUT) else $error("Test mode not shown");

  a_far_dcd_rts: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cfg.flow_ctrl && rts_s) |=> FAR_DCD_CTRL) else $error("Far DCD not forwarded");

  a_ack_pulse: assert property (@(posedge SYS_CLK) disable iff (RST)
    WB_ACK_O |=> !WB_ACK_O) else $error("Ack held longer than one cycle");

  a_loop_start: assert property (@(posedge SYS_CLK) disable iff (RST)
    LOOP_LOCAL_IN [*5] |-> LOCAL_LOOP_START) else $error("Local loopback not started");

  a_remote_start: assert property (@(posedge SYS_CLK) disable iff (RST)
    LOOP_REMOTE_IN [*5] |-> REMOTE_LOOP_START) else $error("Remote loopback not started");

  a_open_rts_high: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!RTS_CONNECTED && cfg.variant == MCLH_VAR_HIGH_BIAS) [*3] |-> rts_s) else $error("Open RTS not asserted");

  a_open_rts_low: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!RTS_CONNECTED && cfg.variant != MCLH_VAR_HIGH_BIAS) [*3] |=> !CTS_OUT) else $error("Open RTS granted CTS");

  a_reset_state: assert property (@(posedge SYS_CLK)
    $fell(RST) |-> (!CTS_OUT && !LOCAL_LOOP_START && !REMOTE_LOOP_START)) else $error("Bad state after reset");

  c_cts_grant:  cover property (@(posedge SYS_CLK) disable iff (RST) $rose(CTS_OUT));
  c_local_loop: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(LOCAL_LOOP_START));
  c_flow_dcd:   cover property (@(posedge SYS_CLK) disable iff (RST) $rose(FAR_DCD_CTRL));
  c_irq:        cover property (@(posedge SYS_CLK) disable iff (RST) $rose(IRQ));
  c_dsr_eia:    cover property (@(posedge SYS_CLK) disable iff (RST) cfg.dsr_eia && testing && IFACE_TEST_ACTIVE);

endmodule

// file: test/mclh_dte_model.sv
// Behavioural model of the DTE that drives the request and loopback leads.
module mclh_dte_model (
  input  wire logic clk,
  input  wire logic rts_cmd,
  input  wire logic drive_cmd,
  input  wire logic ll_cmd,
  input  wire logic rl_cmd,
  input  wire logic tst_cmd,
  output logic      rts,
  output logic      rts_connected,
  output logic      loop_local,
  output logic      loop_remote,
  output logic      test_active
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rts = 1'b0;
    rts_connected = 1'b1;
    loop_local = 1'b0;
    loop_remote = 1'b0;
    test_active = 1'b0;
  end
  // An open lead carries no level, so the line toggles rather than holding its last value.
  always @(posedge clk) begin
    rts_connected <= drive_cmd;
    rts <= drive_cmd ? rts_cmd : ~rts;
    loop_local <= ll_cmd;
    loop_remote <= rl_cmd;
    test_active <= tst_cmd;
  end
endmodule

// file: test/modem_control_lead_handshake_tb.sv
// Self-checking testbench of the control-lead block.
module modem_control_lead_handshake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mclh_pkg::*;
  localparam int DLY = 4;
  logic        clk = 1'b0, rst = 1'b1, car = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic        rts_c = 1'b0, drv_c = 1'b1, ll_c = 1'b0, rl_c = 1'b0, tst_c = 1'b0;
  logic        rts_l, con_l, ll_l, rl_l, tst_l;
  logic [31:0] dat_o;
  logic        ack, cts, dsr, tm, lls, rls, fdcd, alarm, irq;
  int          miscompares = 0;
  int          check_count = 0;

  always #25 clk = ~clk;

  mclh_dte_model i_mclh_dte_model (.clk(clk), .rts_cmd(rts_c), .drive_cmd(drv_c), .ll_cmd(ll_c),
    .rl_cmd(rl_c), .tst_cmd(tst_c), .rts(rts_l), .rts_connected(con_l), .loop_local(ll_l),
    .loop_remote(rl_l), .test_active(tst_l));

  mclh_top #(.CTS_DELAY_CYC(DLY)) i_mclh_top (.SYS_CLK(clk), .RST(rst), .RTS_IN(rts_l),
    .RTS_CONNECTED(con_l), .LOOP_LOCAL_IN(ll_l), .LOOP_REMOTE_IN(rl_l), .OPTICAL_CARRIER_VALID(car),
    .IFACE_TEST_ACTIVE(tst_l), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CTS_OUT(cts), .DSR_OUT(dsr),
    .TEST_MODE_OUT(tm), .LOCAL_LOOP_START(lls), .REMOTE_LOOP_START(rls), .FAR_DCD_CTRL(fdcd),
    .ALARM_CONTACT_CLOSED(alarm), .IRQ(irq));

  task automatic test_done;
    $display("checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Ack is read before the edge's own updates land, which is the value the edge samples.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  task automatic lead(input logic r, input logic c, input logic l, input logic m);
    @(posedge clk);
    rts_c <= r;
    drv_c <= c;
    ll_c <= l;
    rl_c <= m;
  endtask

  task automatic set_car(input logic v);
    @(posedge clk);
    car <= v;
  endtask

  task automatic wait_cts(input logic exp);
    int n;
    n = 0;
    while (cts !== exp && n < 60) begin
      step(1);
      n++;
    end
    chk("cts", exp, cts);
    if (n >= 60) test_done();
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    step(2);
    chk("cts", 0, cts);
    chk("alarm", 1, alarm);
    chk("dsr", 1, dsr);
    chk("loops", 0, {tm, lls, rls});
    rd("id", MCLH_ADR_ID, MCLH_ID_VALUE);
    rd("unmapped", 8'h14, 32'h0);
    rd("ctrl", MCLH_ADR_CTRL, 32'h0);
    set_car(1'b1);
    step(2);
    chk("alarm", 0, alarm);
    wr(MCLH_ADR_CTRL, 32'h10);
    set_car(1'b0);
    step(2);
    chk("alarm", 0, alarm);
    set_car(1'b1);
    step(2);
    chk("alarm", 1, alarm);
    wr(MCLH_ADR_CTRL, 32'h00);
    wr(MCLH_ADR_IRQ, 32'h3F);
    wr(MCLH_ADR_MASK, 32'h01);
    lead(1'b1, 1'b1, 1'b0, 1'b0);
    step(4);
    chk("cts", 0, cts);
    wait_cts(1'b1);
    step(2);
    chk("irq", 1, irq);
    rd("irq status", MCLH_ADR_IRQ, 32'h01);
    wr(MCLH_ADR_IRQ, 32'h01);
    step(2);
    chk("irq", 0, irq);
    chk("far dcd", 0, fdcd);
    wr(MCLH_ADR_CTRL, 32'h04);
    step(4);
    chk("far dcd", 1, fdcd);
    lead(1'b0, 1'b1, 1'b0, 1'b0);
    step(6);
    chk("far dcd", 0, fdcd);
    wait_cts(1'b0);
    step(2);
    chk("irq", 0, irq);
    // Gate on carrier: the delay alone must not release the handshake.
    wr(MCLH_ADR_CTRL, 32'h08);
    set_car(1'b0);
    lead(1'b1, 1'b1, 1'b0, 1'b0);
    step(20);
    chk("cts", 0, cts);
    set_car(1'b1);
    wait_cts(1'b1);
    lead(1'b0, 1'b1, 1'b0, 1'b0);
    wait_cts(1'b0);
    for (int v = 0; v < 4; v++) begin
      wr(MCLH_ADR_CTRL, 32'(v));
      lead(1'b0, 1'b0, 1'b0, 1'b0);
      step(12);
      chk("cts", (v == 1), cts);
      lead(1'b0, 1'b1, 1'b0, 1'b0);
      step(12);
    end
    wr(MCLH_ADR_CTRL, 32'h00);
    lead(1'b0, 1'b1, 1'b1, 1'b0);
    step(8);
    chk("loop", 4'b1010, {lls, rls, tm, dsr});
    lead(1'b0, 1'b1, 1'b0, 1'b1);
    step(8);
    chk("loop", 4'b0110, {lls, rls, tm, dsr});
    lead(1'b0, 1'b1, 1'b0, 1'b0);
    step(8);
    chk("loop", 4'b0001, {lls, rls, tm, dsr});
    // In EIA mode DSR stays on during a loopback only while the interface runs the test.
    wr(MCLH_ADR_CTRL, 32'h20);
    lead(1'b0, 1'b1, 1'b1, 1'b0);
    step(8);
    chk("dsr eia", 0, dsr);
    @(posedge clk);
    tst_c <= 1'b1;
    step(4);
    chk("dsr eia", 1, dsr);
    @(posedge clk);
    tst_c <= 1'b0;
    ll_c <= 1'b0;
    step(8);
    chk("dsr eia", 1, dsr);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
